// ---- artmr_pkg.sv ----
`default_nettype none
package artmr_pkg;
  localparam int CNT_W = 8;
  localparam int WDT_W = 16;
  localparam int CTL_W = 4;
  localparam int CTL_N = 7;
  localparam int SEL_W = 3;
  localparam int NCNT = 5;
  // Control register indices
  localparam logic [2:0] CTL_PRESCALER = 3'h0;
  localparam logic [2:0] CTL_ONE = 3'h1;
  localparam logic [2:0] CTL_TWO = 3'h2;
  localparam logic [2:0] CTL_THREE = 3'h3;
  localparam logic [2:0] CTL_FOUR = 3'h4;
  localparam logic [2:0] CTL_FIVE = 3'h5;
  localparam logic [2:0] CTL_SIX = 3'h6;
  // Field positions
  localparam int BIT_RUN = 0;
  localparam int BIT_SRC = 1;
  localparam int BIT_GATE = 2;
  localparam int BIT_SYNC = 2;
  localparam int BIT_PWM_EN = 0;
  localparam int BIT_CAPTURE = 0;
  // Reset values and the watchdog completion count
  localparam logic [3:0] CTL_RST = 4'h0;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [15:0] WDT_RST = 16'h0000;
  localparam logic [15:0] WDT_LAST = 16'hffff;
endpackage
`default_nettype wire

// ---- artmr_cnt.sv ----
`default_nettype none
module artmr_cnt #(
  parameter int W = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic [W-1:0] i_load_val,
  input wire logic i_restart,
  input wire logic i_tick,
  output logic [W-1:0] o_count,
  output logic o_underflow
);
  logic [W-1:0] reload_reg;
  logic [W-1:0] count_reg;
  logic uf_reg;
  wire at_zero = (count_reg == '0);
  wire underflow_now = i_tick && at_zero;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      reload_reg <= '0;
      count_reg <= '0;
      uf_reg <= 1'b0;
    end
    else
    begin
      uf_reg <= underflow_now && !i_load;
      if (i_load)
      begin
        reload_reg <= i_load_val;
        count_reg <= i_load_val;
      end
      else if (i_restart || underflow_now)
        count_reg <= reload_reg;
      else if (i_tick)
        count_reg <= count_reg - 1'b1;
    end
  end

  assign o_count = count_reg;
  assign o_underflow = uf_reg;
endmodule
`default_nettype wire

// ---- artmr_top.sv ----
`default_nettype none
module artmr_top #(
  parameter int CNT_W = artmr_pkg::CNT_W,
  parameter int WDT_W = artmr_pkg::WDT_W
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ctl_we,
  input wire logic [2:0] i_ctl_sel,
  input wire logic [3:0] i_ctl_data,
  input wire logic i_rld_we,
  input wire logic [2:0] i_rld_sel,
  input wire logic [CNT_W-1:0] i_rld_data,
  input wire logic [3:0] i_irq_clr,
  input wire logic i_wdog_service,
  input wire logic i_ext_irq_pin_a,
  input wire logic i_ext_irq_pin_b,
  output logic [3:0] o_timer_irq,
  output logic o_prescaler_out_clock,
  output logic o_pwm_out_signal,
  output logic [CNT_W-1:0] o_t1_capture,
  output logic o_t1_capture_valid,
  output logic o_wdog_flag,
  output logic o_sys_reset
);
  logic [3:0] ctl_reg [artmr_pkg::CTL_N];
  logic [1:0] pin_a_sync_reg;
  logic [1:0] pin_b_sync_reg;
  logic pin_a_prev_reg;
  logic pin_b_prev_reg;
  logic t3_armed_reg;
  logic [3:0] irq_reg;
  logic presc_out_reg;
  logic pwm_reg;
  logic [CNT_W-1:0] cap_reg;
  logic cap_valid_reg;
  logic [WDT_W-1:0] wdt_reg;
  logic wdf_reg;
  logic sys_rst_reg;
  logic [artmr_pkg::NCNT-1:0] tick;
  logic [artmr_pkg::NCNT-1:0] restart;
  logic [artmr_pkg::NCNT-1:0] uf;
  logic [CNT_W-1:0] cnt_val [artmr_pkg::NCNT];

  // Pins come from outside; both pass two flops before any use
  wire pin_a = pin_a_sync_reg[1];
  wire pin_b = pin_b_sync_reg[1];
  wire pin_a_rise = pin_a && !pin_a_prev_reg;
  wire pin_b_rise = pin_b && !pin_b_prev_reg;

  wire [3:0] ctl_p = ctl_reg[artmr_pkg::CTL_PRESCALER];
  wire [3:0] ctl_1 = ctl_reg[artmr_pkg::CTL_ONE];
  wire [3:0] ctl_2 = ctl_reg[artmr_pkg::CTL_TWO];
  wire [3:0] ctl_3 = ctl_reg[artmr_pkg::CTL_THREE];
  wire [3:0] ctl_4 = ctl_reg[artmr_pkg::CTL_FOUR];
  wire [3:0] ctl_5 = ctl_reg[artmr_pkg::CTL_FIVE];
  wire [3:0] ctl_6 = ctl_reg[artmr_pkg::CTL_SIX];

  // Source 0 is the instruction clock (every cycle), 1 the prescaler output
  wire presc_tick = uf[0];
  wire src1 = ctl_1[artmr_pkg::BIT_SRC] ? presc_tick : 1'b1;
  wire src2 = ctl_2[artmr_pkg::BIT_SRC] ? presc_tick : 1'b1;
  wire src3 = ctl_3[artmr_pkg::BIT_SRC] ? presc_tick : 1'b1;
  wire src4 = ctl_4[artmr_pkg::BIT_SRC] ? presc_tick : 1'b1;
  // Pulse width: count only while pin a is high
  wire t1_gate = ctl_1[artmr_pkg::BIT_GATE] ? pin_a : 1'b1;
  // Period: a rising edge captures the count and restarts the timer
  wire t1_cap = ctl_6[artmr_pkg::BIT_CAPTURE] && pin_a_rise;
  wire t3_go = ctl_3[artmr_pkg::BIT_SYNC] ? t3_armed_reg : 1'b1;

  assign tick[0] = ctl_p[artmr_pkg::BIT_RUN];
  assign tick[1] = ctl_1[artmr_pkg::BIT_RUN] && src1 && t1_gate;
  assign tick[2] = ctl_2[artmr_pkg::BIT_RUN] && src2;
  assign tick[3] = ctl_3[artmr_pkg::BIT_RUN] && src3 && t3_go;
  assign tick[4] = ctl_4[artmr_pkg::BIT_RUN] && src4;
  assign restart[0] = 1'b0;
  assign restart[1] = t1_cap;
  assign restart[2] = 1'b0;
  assign restart[3] = 1'b0;
  assign restart[4] = 1'b0;

  // Prescaler and four timers share one counter shape; reload n divides by n+1
  genvar g;
  generate
    for (g = 0; g < artmr_pkg::NCNT; g++)
    begin : g_cnt
      wire load_hit = i_rld_we && (i_rld_sel == 3'(g));
      artmr_cnt #(
        .W(CNT_W)
      ) u_cnt (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_load(load_hit),
        .i_load_val(i_rld_data),
        .i_restart(restart[g]),
        .i_tick(tick[g]),
        .o_count(cnt_val[g]),
        .o_underflow(uf[g])
      );
    end
  endgenerate

  wire wdt_done = (wdt_reg == artmr_pkg::WDT_LAST);
  wire ctl_hit_ok = i_ctl_we && (i_ctl_sel < 3'(artmr_pkg::CTL_N));

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      for (int i = 0; i < artmr_pkg::CTL_N; i++)
        ctl_reg[i] <= artmr_pkg::CTL_RST;
    end
    else if (ctl_hit_ok)
      ctl_reg[i_ctl_sel] <= i_ctl_data;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pin_a_sync_reg <= 2'h0;
      pin_b_sync_reg <= 2'h0;
      pin_a_prev_reg <= 1'b0;
      pin_b_prev_reg <= 1'b0;
    end
    else
    begin
      pin_a_sync_reg <= {pin_a_sync_reg[0], i_ext_irq_pin_a};
      pin_b_sync_reg <= {pin_b_sync_reg[0], i_ext_irq_pin_b};
      pin_a_prev_reg <= pin_a;
      pin_b_prev_reg <= pin_b;
    end
  end

  // Timer 3 waits for a pin b rising edge; stopping it drops the arm
  always_ff @(posedge i_clk)
  begin
    if (i_rst || !ctl_3[artmr_pkg::BIT_RUN])
      t3_armed_reg <= 1'b0;
    else if (pin_b_rise)
      t3_armed_reg <= 1'b1;
  end

  // A new underflow wins over a clear in the same cycle
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      irq_reg <= 4'h0;
    else
      irq_reg <= (irq_reg & ~i_irq_clr) | uf[4:1];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      presc_out_reg <= 1'b0;
      pwm_reg <= 1'b0;
    end
    else
    begin
      presc_out_reg <= uf[0];
      if (!ctl_5[artmr_pkg::BIT_PWM_EN])
        pwm_reg <= 1'b0;
      else if (uf[4])
        pwm_reg <= !pwm_reg;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cap_reg <= artmr_pkg::CNT_RST;
      cap_valid_reg <= 1'b0;
    end
    else
    begin
      cap_valid_reg <= t1_cap;
      if (t1_cap)
        cap_reg <= cnt_val[1];
    end
  end

  // Free running: no control input reaches it, only system reset
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      wdt_reg <= WDT_W'(artmr_pkg::WDT_RST);
    else
      wdt_reg <= wdt_reg + 1'b1;
  end

  // First completion raises the flag; a second one before service resets
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      wdf_reg <= 1'b0;
      sys_rst_reg <= 1'b0;
    end
    else
    begin
      sys_rst_reg <= wdt_done && wdf_reg;
      if (wdt_done)
        wdf_reg <= 1'b1;
      else if (i_wdog_service)
        wdf_reg <= 1'b0;
    end
  end

  assign o_timer_irq = irq_reg;
  assign o_prescaler_out_clock = presc_out_reg;
  assign o_pwm_out_signal = pwm_reg;
  assign o_t1_capture = cap_reg;
  assign o_t1_capture_valid = cap_valid_reg;
  assign o_wdog_flag = wdf_reg;
  assign o_sys_reset = sys_rst_reg;
endmodule
`default_nettype wire

// ---- artmr_top_checker.sv ----
`default_nettype none
module artmr_checker (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ctl_we,
  input wire logic [2:0] i_ctl_sel,
  input wire logic [3:0] i_ctl_data,
  input wire logic [3:0] i_irq_clr,
  input wire logic i_wdog_service,
  input wire logic [3:0] o_timer_irq,
  input wire logic o_prescaler_out_clock,
  input wire logic o_pwm_out_signal,
  input wire logic o_t1_capture_valid,
  input wire logic o_wdog_flag,
  input wire logic o_sys_reset
);
  // Shadow of the watchdog count; it never stops, so it mirrors the real one
  logic [15:0] wcnt_reg;
  logic prun_reg;
  logic pwm_reg;
  logic [3:0] keep;
  assign keep = o_timer_irq & ~i_irq_clr;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      wcnt_reg <= 16'h0000;
      prun_reg <= 1'h0;
      pwm_reg <= 1'h0;
    end
    else
    begin
      wcnt_reg <= wcnt_reg + 16'h0001;
      if (i_ctl_we && i_ctl_sel == 3'h0)
        prun_reg <= i_ctl_data[0];
      if (i_ctl_we && i_ctl_sel == 3'h5)
        pwm_reg <= i_ctl_data[0];
    end
  end
  wdog_period_a:
    assert property ($rose(o_wdog_flag) |-> wcnt_reg == 16'h0000) else $error("wdog period");
  sysrst_timing_a:
    assert property (o_sys_reset |-> wcnt_reg == 16'h0000 && $past(o_wdog_flag))
    else $error("sys reset timing");
  wdog_hold_a:
    assert property (o_wdog_flag && !i_wdog_service |=> o_wdog_flag) else $error("wdog flag lost");
  irq_sticky_a:
    assert property (1'h1 |=> (o_timer_irq & $past(keep)) == $past(keep)) else $error("irq lost");
  reset_clear_a:
    assert property (disable iff (1'h0) i_rst |=> o_timer_irq == 4'h0 && !o_wdog_flag
      && !o_sys_reset && !o_pwm_out_signal && !o_prescaler_out_clock) else $error("reset");
  presc_idle_a:
    assert property (!prun_reg && !$past(prun_reg) && !$past(prun_reg, 2)
      |-> !o_prescaler_out_clock) else $error("prescaler idle");
  pwm_off_a:
    assert property (!pwm_reg && !$past(pwm_reg) && !$past(pwm_reg, 2) |-> !o_pwm_out_signal)
    else $error("pwm off");
  capture_pulse_a:
    assert property (o_t1_capture_valid |=> !o_t1_capture_valid) else $error("capture pulse");
endmodule
bind artmr_top artmr_checker chk (.i_clk, .i_rst, .i_ctl_we, .i_ctl_sel, .i_ctl_data,
  .i_irq_clr, .i_wdog_service, .o_timer_irq, .o_prescaler_out_clock, .o_pwm_out_signal,
  .o_t1_capture_valid, .o_wdog_flag, .o_sys_reset);
`default_nettype wire

// ---- tb_artmr_top.sv ----
`default_nettype none
module tb_artmr_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'h0, i_rst = 1'h1, i_ctl_we = 1'h0, i_rld_we = 1'h0, i_wdog_service = 1'h0;
  logic i_ext_irq_pin_a = 1'h0, i_ext_irq_pin_b = 1'h0, o_prescaler_out_clock, o_pwm_out_signal;
  logic o_t1_capture_valid, o_wdog_flag, o_sys_reset, prv = 1'h1;
  logic [2:0] i_ctl_sel = 3'h0, i_rld_sel = 3'h0;
  logic [3:0] i_ctl_data = 4'h0, i_irq_clr = 4'h0, o_timer_irq;
  logic [7:0] i_rld_data = 8'h00, o_t1_capture;
  int miscompares = 0, total_checks = 0, cyc = 0, rel = 0, c;
  always #2 i_clk = ~i_clk;
  always @(posedge i_clk) cyc <= cyc + 1;
  artmr_top dut (.i_clk, .i_rst, .i_ctl_we, .i_ctl_sel, .i_ctl_data, .i_rld_we, .i_rld_sel,
    .i_rld_data, .i_irq_clr, .i_wdog_service, .i_ext_irq_pin_a, .i_ext_irq_pin_b, .o_timer_irq,
    .o_prescaler_out_clock, .o_pwm_out_signal, .o_t1_capture, .o_t1_capture_valid,
    .o_wdog_flag, .o_sys_reset);
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %0d seen %0d", s, e, g);
    end
  endtask
  task automatic wr(input logic r, input logic [2:0] s, input logic [7:0] d);
    @(posedge i_clk);
    i_ctl_we <= !r;
    i_rld_we <= r;
    i_ctl_sel <= s;
    i_rld_sel <= s;
    i_ctl_data <= d[3:0];
    i_rld_data <= d;
    @(posedge i_clk);
    i_ctl_we <= 1'h0;
    i_rld_we <= 1'h0;
  endtask
  // Flags are counted by rising edge and cleared at once; a window of whole periods is exact
  task automatic win(input int k, input int w, output int n);
    logic v;
    n = 0;
    repeat (w)
    begin
      @(posedge i_clk);
      v = k < 4 ? o_timer_irq[k] : k == 4 ? o_prescaler_out_clock : o_pwm_out_signal;
      n += k < 4 ? int'(v && !prv) : int'(v);
      prv = v;
      if (k < 4)
        i_irq_clr <= v ? 4'h1 << k : 4'h0;
    end
  endtask
  // Drive pin a high for h cycles, then low for l cycles
  task automatic pulse_a(input int h, input int l);
    i_ext_irq_pin_a <= 1'h1;
    repeat (h) @(posedge i_clk);
    i_ext_irq_pin_a <= 1'h0;
    repeat (l) @(posedge i_clk);
  endtask
  // Waits for one capture pulse and judges the count standing with it
  task automatic cap(input logic [7:0] e);
    logic seen;
    seen = 1'h0;
    repeat (8)
    begin
      @(posedge i_clk);
      if (!seen && o_t1_capture_valid === 1'h1)
      begin
        seen = 1'h1;
        chk("capture count", e, o_t1_capture);
      end
    end
    chk("capture pulse", 1, seen);
  endtask
  // Period: rises 10 cycles apart; the restart reloads n, then nine ticks pass
  // Pulse width: a 5 cycle high level takes five ticks off the loaded count
  task automatic t_capture;
    wr(1'h1, 3'h1, 8'h10);
    i_ext_irq_pin_a <= 1'h0;
    repeat (6) @(posedge i_clk);
    pulse_a(5, 5);
    i_ext_irq_pin_a <= 1'h1;
    cap(8'h10 - 8'h09);
    wr(1'h0, 3'h6, 8'h00);
    wr(1'h0, 3'h1, 8'h05);
    i_ext_irq_pin_a <= 1'h0;
    repeat (4) @(posedge i_clk);
    wr(1'h1, 3'h1, 8'h10);
    pulse_a(5, 6);
    wr(1'h0, 3'h6, 8'h01);
    i_ext_irq_pin_a <= 1'h1;
    cap(8'h10 - 8'h05);
    $display("capture done");
  endtask
  task automatic t_timers;
    logic [7:0] ns [4] = '{8'h02, 8'h05, 8'h0c, 8'hff};
    for (int k = 0; k < 4; k++)
    begin
      wr(1'h1, 3'(k + 1), ns[k]);
      wr(1'h0, 3'(k + 1), 8'h01);
      win(k, ns[k] + 1, c);
      win(k, 4 * (ns[k] + 1), c);
      chk("timer underflows", 4, c);
    end
    $display("timers done");
  endtask
  task automatic t_presc;
    for (int i = 0; i < 2; i++)
    begin
      wr(1'h1, 3'h0, i ? 8'hff : 8'h00);
      wr(1'h0, 3'h0, 8'h01);
      win(4, 256, c);
      win(4, i ? 1024 : 4, c);
      chk("prescaler pulses", 4, c);
    end
    wr(1'h0, 3'h0, 8'h00);
    win(4, 8, c);
    win(4, 16, c);
    chk("prescaler stopped", 0, c);
    $display("prescaler done");
  endtask
  task automatic t_pwm;
    wr(1'h1, 3'h4, 8'h03);
    wr(1'h0, 3'h5, 8'h01);
    win(5, 16, c);
    win(5, 32, c);
    chk("pwm high", 16, c);
    wr(1'h0, 3'h5, 8'h00);
    win(5, 8, c);
    win(5, 16, c);
    chk("pwm off", 0, c);
    $display("pwm done");
  endtask
  task automatic t_gate;
    wr(1'h0, 3'h3, 8'h00);
    wr(1'h1, 3'h3, 8'h02);
    wr(1'h0, 3'h3, 8'h05);
    wr(1'h0, 3'h6, 8'h01);
    win(2, 8, c);
    win(2, 24, c);
    chk("timer3 held", 0, c);
    i_ext_irq_pin_b <= 1'h1;
    i_ext_irq_pin_a <= 1'h1;
    win(2, 12, c);
    win(2, 24, c);
    chk("timer3 started", 8, c);
    $display("gate done");
  endtask
  task automatic t_wdog;
    repeat (70000)
    begin
      @(posedge i_clk);
      if (o_wdog_flag === 1'h1)
        break;
    end
    chk("wdog period", 1, cyc - rel > 65533 && cyc - rel < 65541);
    chk("first completion no reset", 0, o_sys_reset);
    i_wdog_service <= 1'h1;
    @(posedge i_clk);
    i_wdog_service <= 1'h0;
    repeat (2) @(posedge i_clk);
    chk("wdog service", 0, o_wdog_flag);
    $display("watchdog done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge i_clk);
    i_rst <= 1'h0;
    rel = cyc;
    t_timers();
    t_presc();
    t_pwm();
    t_gate();
    t_capture();
    t_wdog();
    complete_run();
  end
  initial
  begin
    #320000;
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
